// file: hw/power_mode_wakeup_ctrl.sv
// power mode sequencing, wake-up timers, clock control and register slave
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module power_mode_wakeup_ctrl #(
    parameter int IRC_START_CYC = pwr_wake_pkg::IRC_START_CYCLES,
    parameter int FLASH_WAKE_CYC = pwr_wake_pkg::FLASH_WAKE_CYCLES
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    // core and interrupt controller
    input wire logic CPU_IDLE,
    input wire logic [1:0] MODE_REQ,
    input wire logic [31:0] WAKE_MASK,
    output logic CPU_WAKE,
    output logic CPU_CLK_EN,
    output logic [1:0] CPU_CLK_SRC,
    output logic [7:0] CPU_CLK_DIV,
    // asynchronous pins and domains
    input wire logic [31:0] IRQ_LINES,
    input wire logic RTC_ALARM,
    input wire logic RTC_DPD_REQ,
    input wire logic MAIN_OSC_OK,
    input wire logic CORE_SUPPLY_OK,
    // oscillators and plls
    output logic MAIN_OSC_EN,
    output logic MAIN_PLL_EN,
    output logic MAIN_PLL_CONNECT,
    output logic USB_PLL_EN,
    output logic USB_PLL_PWR,
    output logic USB_CLK_FROM_USB_PLL,
    output logic [7:0] USB_CLK_DIV,
    output logic IRC_OUT_EN,
    output logic IRC_PWR_EN,
    output logic RTC_OSC_EN,
    output logic RTC_SUPPLY_BATTERY,
    // flash
    output logic FLASH_PWR_EN,
    output logic FLASH_ACCESS_EN,
    // clock output and peripherals
    output logic CLKOUT_EN,
    output logic [2:0] CLKOUT_SEL,
    output logic [7:0] PERIPH_CLK_EN,
    output logic DEEP_PD_ACTIVE
);
    typedef enum logic [2:0] {
        ST_RUN, ST_SLEEP, ST_DSLEEP, ST_PDOWN, ST_DPD, ST_IRC_START, ST_RESUME
    } state_type;

    localparam int SYNC_W = pwr_wake_pkg::NUM_IRQ + 4;

    function automatic logic div_hit(input logic [2:0] cnt, input logic [1:0] code);
        logic [2:0] mask;
        mask = 3'((4'h1 << code) - 4'h1);
        return (cnt & mask) == 3'h0;
    endfunction

    // reset release
    logic rst_s1_reg, rst_n;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    // three-stage input capture, value accepted when stages two and three agree
    wire [SYNC_W-1:0] async_in = {IRQ_LINES, RTC_ALARM, RTC_DPD_REQ, MAIN_OSC_OK, CORE_SUPPLY_OK};
    logic [SYNC_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            filt_reg <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
        end
    end
    wire [31:0] irq_s = filt_reg[SYNC_W-1:4];
    wire alarm_s = filt_reg[3];
    wire dpd_req_s = filt_reg[2];
    wire osc_ok_s = filt_reg[1];
    wire supply_ok_s = filt_reg[0];

    // control registers and state
    pwr_wake_pkg::clk_ctrl_type ctrl_reg;
    logic [7:0] cpu_div_reg, usb_div_reg, gate_reg;
    logic [15:0] pdiv_reg;
    logic [2:0] cko_sel_reg;
    logic cko_en_reg;
    state_type state_reg, state_next;
    logic [15:0] wait_reg, wait_next;
    logic [15:0] osc_cnt_reg, flash_cnt_reg;
    logic osc_safe_reg, flash_ok_reg, flash_run_reg;
    logic [31:0] mask_reg;
    logic prior_main_reg;
    logic [2:0] pcnt_reg;

    // bus address phase
    logic wr_pend_reg, rd_pend_reg;
    logic [7:0] addr_reg;
    wire bus_take = HSEL && HTRANS[1] && HREADY;
    wire [7:0] ofs = addr_reg;

    // state machine decode
    wire run_idle = (state_reg == ST_RUN) && CPU_IDLE;
    wire ds_wake = (|(irq_s & mask_reg)) || alarm_s;
    wire enter_ds = run_idle && (MODE_REQ == pwr_wake_pkg::MODE_DEEP_SLEEP);
    wire enter_pd = run_idle && (MODE_REQ == pwr_wake_pkg::MODE_POWER_DOWN);
    wire enter_dpd = run_idle && (MODE_REQ == pwr_wake_pkg::MODE_DEEP_PD) && dpd_req_s;
    wire clocks_stopped = (state_reg == ST_DSLEEP) || (state_reg == ST_PDOWN)
        || (state_reg == ST_DPD) || (state_reg == ST_IRC_START);
    wire rc_powered = (state_reg != ST_PDOWN) && (state_reg != ST_DPD);
    wire pd_wake_done = (state_reg == ST_IRC_START) && (wait_reg == 16'h0000);
    wire [15:0] ds_resume = (prior_main_reg)
        ? 16'(pwr_wake_pkg::DS_MAIN_RESUME_CYCLES - 1)
        : 16'(pwr_wake_pkg::DS_IRC_RESUME_CYCLES - 1);

    always_comb begin
        state_next = state_reg;
        wait_next = (wait_reg != 16'h0000) ? wait_reg - 16'h0001 : wait_reg;
        unique case (state_reg)
            ST_RUN: begin
                if (run_idle) begin
                    unique case (MODE_REQ)
                        pwr_wake_pkg::MODE_SLEEP: state_next = ST_SLEEP;
                        pwr_wake_pkg::MODE_DEEP_SLEEP: state_next = ST_DSLEEP;
                        pwr_wake_pkg::MODE_POWER_DOWN: state_next = ST_PDOWN;
                        pwr_wake_pkg::MODE_DEEP_PD: begin
                            if (dpd_req_s) begin
                                state_next = ST_DPD;
                            end
                        end
                    endcase
                end
            end
            ST_SLEEP: begin
                if (|irq_s) begin
                    state_next = ST_RUN;
                end
            end
            ST_DSLEEP: begin
                if (ds_wake) begin
                    state_next = ST_RESUME;
                    wait_next = ds_resume;
                end
            end
            ST_PDOWN: begin
                if (ds_wake) begin
                    state_next = ST_IRC_START;
                    wait_next = 16'(IRC_START_CYC - 1);
                end
            end
            ST_DPD: begin
                if (alarm_s) begin
                    state_next = ST_IRC_START;
                    wait_next = 16'(IRC_START_CYC - 1);
                end
            end
            ST_IRC_START: begin
                if (wait_reg == 16'h0000) begin
                    state_next = ST_RESUME;
                    wait_next = 16'(pwr_wake_pkg::PD_RESUME_CYCLES - 1);
                end
            end
            ST_RESUME: begin
                if (wait_reg == 16'h0000) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_RUN;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_RUN;
            wait_reg <= 16'h0000;
            mask_reg <= '0;
            prior_main_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            if (run_idle) begin
                mask_reg <= WAKE_MASK;
                prior_main_reg <= (ctrl_reg.src != pwr_wake_pkg::SRC_IRC);
            end
        end
    end

    // main oscillator wake-up timer
    wire osc_running = ctrl_reg.main_osc_en && !clocks_stopped && osc_ok_s;
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt_reg <= 16'h0000;
            osc_safe_reg <= 1'b0;
        end else if (!osc_running) begin
            osc_cnt_reg <= 16'h0000;
            osc_safe_reg <= 1'b0;
        end else if (osc_cnt_reg == 16'(pwr_wake_pkg::OSC_SAFE_CYCLES - 1)) begin
            osc_safe_reg <= 1'b1;
        end else begin
            osc_cnt_reg <= osc_cnt_reg + 16'h0001;
        end
    end

    // flash wake-up timer, restarted when the irc start-up wait ends after flash power returns
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            flash_cnt_reg <= 16'h0000;
            flash_ok_reg <= 1'b0;
            flash_run_reg <= 1'b1;
        end else if (!rc_powered) begin
            flash_cnt_reg <= 16'h0000;
            flash_ok_reg <= 1'b0;
            flash_run_reg <= 1'b0;
        end else if (pd_wake_done) begin
            flash_run_reg <= 1'b1;
        end else if (flash_run_reg) begin
            if (flash_cnt_reg == 16'(FLASH_WAKE_CYC - 1)) begin
                flash_ok_reg <= 1'b1;
                flash_run_reg <= 1'b0;
            end else begin
                flash_cnt_reg <= flash_cnt_reg + 16'h0001;
            end
        end
    end

    // register writes and mode side effects
    wire do_wr = wr_pend_reg;
    wire [1:0] wr_src = HWDATA[pwr_wake_pkg::CTRL_SRC_LSB +: 2];
    wire src_ok = (wr_src == pwr_wake_pkg::SRC_IRC)
        || ((wr_src == pwr_wake_pkg::SRC_MAIN_OSC) && osc_safe_reg)
        || ((wr_src == pwr_wake_pkg::SRC_MAIN_PLL) && ctrl_reg.main_pll_en);
    wire cko_ok = HWDATA[2:0] <= pwr_wake_pkg::CKO_USB;
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= pwr_wake_pkg::CLK_CTRL_RESET;
            cpu_div_reg <= pwr_wake_pkg::CPU_DIV_RESET;
            usb_div_reg <= pwr_wake_pkg::USB_DIV_RESET;
            gate_reg <= pwr_wake_pkg::PERIPH_GATE_RESET;
            pdiv_reg <= pwr_wake_pkg::PERIPH_DIV_RESET;
            cko_sel_reg <= pwr_wake_pkg::CKO_CPU;
            cko_en_reg <= 1'b0;
        end else if (enter_ds || enter_pd || enter_dpd) begin
            ctrl_reg.main_pll_en <= 1'b0;
            ctrl_reg.main_pll_conn <= 1'b0;
            cpu_div_reg <= 8'h00;
            usb_div_reg <= 8'h00;
            if (ctrl_reg.src == pwr_wake_pkg::SRC_MAIN_PLL) begin
                ctrl_reg.src <= pwr_wake_pkg::SRC_IRC;
            end
        end else if (pd_wake_done) begin
            ctrl_reg.src <= pwr_wake_pkg::SRC_IRC;
        end else if (do_wr) begin
            unique case (ofs)
                pwr_wake_pkg::CLK_CTRL_OFS: begin
                    ctrl_reg.main_osc_en <= HWDATA[pwr_wake_pkg::CTRL_OSC_BIT];
                    ctrl_reg.main_pll_en <= HWDATA[pwr_wake_pkg::CTRL_PLL_EN_BIT];
                    ctrl_reg.main_pll_conn <= HWDATA[pwr_wake_pkg::CTRL_PLL_CONN_BIT];
                    ctrl_reg.usb_pll_en <= HWDATA[pwr_wake_pkg::CTRL_USB_PLL_BIT];
                    if (src_ok) begin
                        ctrl_reg.src <= wr_src;
                    end
                end
                pwr_wake_pkg::CLK_DIV_OFS: begin
                    cpu_div_reg <= HWDATA[7:0];
                    usb_div_reg <= HWDATA[pwr_wake_pkg::DIV_USB_LSB +: 8];
                end
                pwr_wake_pkg::CLK_OUT_OFS: begin
                    if (cko_ok) begin
                        cko_sel_reg <= HWDATA[2:0];
                    end
                    cko_en_reg <= HWDATA[pwr_wake_pkg::CLKOUT_EN_BIT];
                end
                pwr_wake_pkg::PERIPH_GATE_OFS: gate_reg <= HWDATA[7:0];
                pwr_wake_pkg::PERIPH_DIV_OFS: pdiv_reg <= HWDATA[15:0];
                default: begin
                end
            endcase
        end
    end

    // read mux
    wire [31:0] status_word = {24'h000000, RTC_SUPPLY_BATTERY, prior_main_reg,
        1'b0, state_reg, flash_ok_reg, osc_safe_reg};
    wire [31:0] rd_word =
        (ofs == pwr_wake_pkg::CLK_CTRL_OFS) ? {26'h0000000, ctrl_reg} :
        (ofs == pwr_wake_pkg::CLK_DIV_OFS) ? {16'h0000, usb_div_reg, cpu_div_reg} :
        (ofs == pwr_wake_pkg::CLK_OUT_OFS) ? {27'h0000000, cko_en_reg, 1'b0, cko_sel_reg} :
        (ofs == pwr_wake_pkg::PERIPH_GATE_OFS) ? {24'h000000, gate_reg} :
        (ofs == pwr_wake_pkg::PERIPH_DIV_OFS) ? {16'h0000, pdiv_reg} :
        (ofs == pwr_wake_pkg::STATUS_OFS) ? status_word : 32'h00000000;

    // ahb-lite: writes without wait, reads take one wait state
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            HRDATA <= 32'h00000000;
        end else if (rd_pend_reg) begin
            rd_pend_reg <= 1'b0;
            HRDATA <= rd_word;
            HREADYOUT <= 1'b1;
        end else begin
            wr_pend_reg <= bus_take && HWRITE;
            rd_pend_reg <= bus_take && !HWRITE;
            HREADYOUT <= !(bus_take && !HWRITE);
            if (bus_take) begin
                addr_reg <= {HADDR[7:2], 2'b00};
            end
        end
    end

    // peripheral divider phase counter
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pcnt_reg <= 3'h0;
        end else begin
            pcnt_reg <= pcnt_reg + 3'h1;
        end
    end

    logic [7:0] pclk_next;
    always_comb begin
        for (int i = 0; i < pwr_wake_pkg::NUM_PERIPH; i++) begin
            pclk_next[i] = gate_reg[i] && div_hit(pcnt_reg, pdiv_reg[2*i +: 2]);
        end
    end

    // output stage
    wire periph_run = (state_reg == ST_RUN) || (state_reg == ST_SLEEP)
        || (state_reg == ST_RESUME && wait_reg == 16'h0000);
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            CPU_WAKE <= 1'b0;
            CPU_CLK_EN <= 1'b0;
            CPU_CLK_SRC <= pwr_wake_pkg::SRC_IRC;
            CPU_CLK_DIV <= pwr_wake_pkg::CPU_DIV_RESET;
            MAIN_OSC_EN <= 1'b0;
            MAIN_PLL_EN <= 1'b0;
            MAIN_PLL_CONNECT <= 1'b0;
            USB_PLL_EN <= 1'b0;
            USB_PLL_PWR <= 1'b0;
            USB_CLK_FROM_USB_PLL <= 1'b0;
            USB_CLK_DIV <= pwr_wake_pkg::USB_DIV_RESET;
            IRC_OUT_EN <= 1'b1;
            IRC_PWR_EN <= 1'b1;
            RTC_OSC_EN <= 1'b1;
            RTC_SUPPLY_BATTERY <= 1'b1;
            FLASH_PWR_EN <= 1'b1;
            FLASH_ACCESS_EN <= 1'b0;
            CLKOUT_EN <= 1'b0;
            CLKOUT_SEL <= pwr_wake_pkg::CKO_CPU;
            PERIPH_CLK_EN <= 8'h00;
            DEEP_PD_ACTIVE <= 1'b0;
        end else begin
            CPU_WAKE <= (state_reg != ST_RUN) && (state_next == ST_RUN);
            CPU_CLK_EN <= state_next == ST_RUN;
            CPU_CLK_SRC <= ctrl_reg.src;
            CPU_CLK_DIV <= cpu_div_reg;
            MAIN_OSC_EN <= ctrl_reg.main_osc_en && !clocks_stopped;
            MAIN_PLL_EN <= ctrl_reg.main_pll_en && !clocks_stopped;
            MAIN_PLL_CONNECT <= ctrl_reg.main_pll_conn && ctrl_reg.main_pll_en;
            USB_PLL_PWR <= ctrl_reg.usb_pll_en && !clocks_stopped;
            USB_PLL_EN <= ctrl_reg.usb_pll_en && osc_safe_reg;
            USB_CLK_FROM_USB_PLL <= ctrl_reg.usb_pll_en && osc_safe_reg;
            USB_CLK_DIV <= usb_div_reg;
            IRC_OUT_EN <= !clocks_stopped;
            IRC_PWR_EN <= rc_powered;
            RTC_OSC_EN <= 1'b1;
            RTC_SUPPLY_BATTERY <= !supply_ok_s;
            FLASH_PWR_EN <= rc_powered;
            FLASH_ACCESS_EN <= flash_ok_reg && rc_powered;
            CLKOUT_EN <= cko_en_reg && !clocks_stopped;
            CLKOUT_SEL <= cko_sel_reg;
            PERIPH_CLK_EN <= periph_run ? pclk_next : 8'h00;
            DEEP_PD_ACTIVE <= state_reg == ST_DPD;
        end
    end
endmodule

// file: hw/pwr_wake_pkg.sv
// shared constants and types for the power mode and wake-up controller
package pwr_wake_pkg;
    // clock rate and documented timing
    localparam int CLK_MHZ = 100;
    localparam int IRC_START_US = 60;
    localparam int FLASH_START_US = 100;
    localparam int IRC_START_CYCLES = IRC_START_US * CLK_MHZ;
    localparam int FLASH_WAKE_CYCLES = FLASH_START_US * CLK_MHZ;
    localparam int DS_IRC_RESUME_CYCLES = 4;
    localparam int DS_MAIN_RESUME_CYCLES = 4096;
    localparam int PD_RESUME_CYCLES = 4;
    localparam int OSC_SAFE_CYCLES = 4096;
    localparam int NUM_IRQ = 32;
    localparam int NUM_PERIPH = 8;

    // register byte offsets
    localparam logic [7:0] CLK_CTRL_OFS = 8'h00;
    localparam logic [7:0] CLK_DIV_OFS = 8'h04;
    localparam logic [7:0] CLK_OUT_OFS = 8'h08;
    localparam logic [7:0] PERIPH_GATE_OFS = 8'h0C;
    localparam logic [7:0] PERIPH_DIV_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;

    // field positions
    localparam int CTRL_OSC_BIT = 0;
    localparam int CTRL_PLL_EN_BIT = 1;
    localparam int CTRL_PLL_CONN_BIT = 2;
    localparam int CTRL_USB_PLL_BIT = 3;
    localparam int CTRL_SRC_LSB = 4;
    localparam int DIV_USB_LSB = 8;
    localparam int CLKOUT_EN_BIT = 4;

    // reset values
    localparam logic [7:0] CPU_DIV_RESET = 8'h00;
    localparam logic [7:0] USB_DIV_RESET = 8'h00;
    localparam logic [7:0] PERIPH_GATE_RESET = 8'hFF;
    localparam logic [15:0] PERIPH_DIV_RESET = 16'h0000;

    // mode request codes
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_DEEP_SLEEP = 2'h1;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h2;
    localparam logic [1:0] MODE_DEEP_PD = 2'h3;

    // cpu clock sources
    localparam logic [1:0] SRC_IRC = 2'h0;
    localparam logic [1:0] SRC_MAIN_OSC = 2'h1;
    localparam logic [1:0] SRC_MAIN_PLL = 2'h2;

    // clock output sources
    localparam logic [2:0] CKO_CPU = 3'h0;
    localparam logic [2:0] CKO_IRC = 3'h1;
    localparam logic [2:0] CKO_MAIN_OSC = 3'h2;
    localparam logic [2:0] CKO_RTC = 3'h3;
    localparam logic [2:0] CKO_USB = 3'h4;

    typedef struct packed {
        logic [1:0] src;
        logic usb_pll_en;
        logic main_pll_conn;
        logic main_pll_en;
        logic main_osc_en;
    } clk_ctrl_type;

    localparam clk_ctrl_type CLK_CTRL_RESET = '{SRC_IRC, 1'b0, 1'b0, 1'b0, 1'b0};
endpackage

// file: verif/cpu_core_model.sv
// behavioural core and interrupt controller facing the wake-up logic
`timescale 1ns/1ps
module cpu_core_model (
    // clock and run status
    input wire logic CORE_CLK,
    input wire logic CPU_CLK_EN,
    // low-power request
    output logic CPU_IDLE,
    output logic [1:0] MODE_REQ,
    output logic [31:0] WAKE_MASK
);
    initial begin
        {CPU_IDLE, MODE_REQ, WAKE_MASK} = '0;
    end
    // go idle with a mode; give up after a bounded wait if kept running
    task automatic enter(input logic [1:0] mode, input logic [31:0] en, input logic [31:0] pri);
        repeat (8) @(posedge CORE_CLK);
        MODE_REQ <= mode;
        WAKE_MASK <= en & pri;
        CPU_IDLE <= 1'b1;
        for (int i = 0; i < 12 && CPU_CLK_EN !== 1'b0; i++) begin
            @(negedge CORE_CLK);
        end
        @(posedge CORE_CLK);
        CPU_IDLE <= 1'b0;
        @(negedge CORE_CLK);
    endtask
endmodule

// file: verif/power_mode_wakeup_ctrl_tb.sv
// self-checking bench for the power mode and wake-up controller
`timescale 1ns/1ps
module power_mode_wakeup_ctrl_tb;
    logic CORE_CLK, RSTN, HSEL, HWRITE, HREADYOUT, HRESP, CPU_IDLE, CPU_WAKE, CPU_CLK_EN;
    logic RTC_ALARM, RTC_DPD_REQ, MAIN_OSC_OK, CORE_SUPPLY_OK, MAIN_OSC_EN, MAIN_PLL_EN;
    logic MAIN_PLL_CONNECT, USB_PLL_EN, USB_PLL_PWR, USB_CLK_FROM_USB_PLL, IRC_OUT_EN;
    logic IRC_PWR_EN, RTC_OSC_EN, RTC_SUPPLY_BATTERY, FLASH_PWR_EN, FLASH_ACCESS_EN;
    logic CLKOUT_EN, DEEP_PD_ACTIVE;
    logic [1:0] HTRANS, MODE_REQ, CPU_CLK_SRC;
    logic [2:0] CLKOUT_SEL;
    logic [7:0] CPU_CLK_DIV, USB_CLK_DIV, PERIPH_CLK_EN;
    logic [31:0] HADDR, HWDATA, HRDATA, WAKE_MASK, IRQ_LINES, rd;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int pulses = 0;
    power_mode_wakeup_ctrl #(.IRC_START_CYC(20), .FLASH_WAKE_CYC(30)) u_dut (
        .HSIZE(3'h2), .HREADY(HREADYOUT), .*);
    cpu_core_model u_core (.*);
    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end
    always @(posedge CORE_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_rdy();
        logic rdy;
        do begin
            @(negedge CORE_CLK);
            rdy = HREADYOUT;
            rd = HRDATA;
            @(posedge CORE_CLK);
        end while (rdy !== 1'b1);
    endtask
    task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge CORE_CLK);
        {HSEL, HTRANS, HADDR, HWRITE} <= {3'h6, 24'h0, a, w};
        wait_rdy();
        {HTRANS, HWDATA} <= {2'h0, wd};
        wait_rdy();
        HSEL <= 1'b0;
        // outputs follow the written register one flop later
        repeat (2) @(negedge CORE_CLK);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rw(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // raise a wake source and time the resume pulse
    task automatic kick(input logic [31:0] irq, input logic alarm, input int lo, input int hi);
        int n;
        @(posedge CORE_CLK);
        {IRQ_LINES, RTC_ALARM} <= {irq, alarm};
        n = 0;
        do begin
            @(negedge CORE_CLK);
            n++;
        end while (CPU_WAKE !== 1'b1 && n < hi);
        chk(n >= lo && CPU_WAKE === 1'b1, 1);
        @(posedge CORE_CLK);
        {IRQ_LINES, RTC_ALARM} <= '0;
        @(negedge CORE_CLK);
    endtask
    task test_done();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        {RSTN, HSEL, HWRITE, RTC_ALARM, RTC_DPD_REQ, MAIN_OSC_OK, HTRANS} = '0;
        {HADDR, HWDATA, IRQ_LINES} = '0;
        CORE_SUPPLY_OK = 1'b1;
        repeat (4) @(posedge CORE_CLK);
        RSTN <= 1'b1;
        repeat (12) @(negedge CORE_CLK);
        chk({USB_PLL_EN, USB_PLL_PWR, USB_CLK_FROM_USB_PLL, RTC_SUPPLY_BATTERY}, 0);
        chk(CPU_CLK_SRC, pwr_wake_pkg::SRC_IRC);
        rdc(8'h0C, 32'hFF);
        rw(1'b1, 8'h0C, 32'h5A);
        rdc(8'h0C, 32'h5A);
        rw(1'b1, 8'h10, 32'hE4);
        rdc(8'h10, 32'hE4);
        rd = '0;
        repeat (8) begin
            @(negedge CORE_CLK);
            rd = rd | 32'(PERIPH_CLK_EN);
            pulses += $countones(PERIPH_CLK_EN);
        end
        chk(rd, 32'h5A);
        chk(pulses, 21);
        rdc(8'h40, 32'h0);
        chk(HRESP, 0);
        for (int i = 0; i < 6; i++) begin
            rw(1'b1, 8'h08, i + 16);
            chk({CLKOUT_EN, CLKOUT_SEL}, 8 + (i < 5 ? i : 4));
        end
        @(posedge CORE_CLK);
        MAIN_OSC_OK <= 1'b1;
        rw(1'b1, 8'h00, 32'h11);
        chk({MAIN_OSC_EN, CPU_CLK_SRC}, 3'h4);
        repeat (4120) @(posedge CORE_CLK);
        rw(1'b0, 8'h14, 32'h0);
        chk(rd[0], 1);
        rw(1'b1, 8'h00, 32'h1F);
        chk({CPU_CLK_SRC, USB_PLL_EN, USB_CLK_FROM_USB_PLL, USB_PLL_PWR, MAIN_PLL_CONNECT}, 6'h1F);
        rw(1'b1, 8'h04, 32'h0503);
        u_core.enter(pwr_wake_pkg::MODE_SLEEP, 0, 0);
        chk({CPU_CLK_EN, IRC_OUT_EN, MAIN_OSC_EN}, 3'h3);
        chk(PERIPH_CLK_EN & 8'h50, 8'h50);
        kick(4, 0, 4, 16);
        u_core.enter(pwr_wake_pkg::MODE_DEEP_SLEEP, 3, 2);
        chk({IRC_OUT_EN, IRC_PWR_EN, FLASH_PWR_EN, RTC_OSC_EN, MAIN_PLL_EN}, 5'hE);
        chk({CPU_CLK_DIV, USB_CLK_DIV, MAIN_PLL_CONNECT}, 0);
        chk(PERIPH_CLK_EN, 0);
        @(posedge CORE_CLK);
        IRQ_LINES <= 1;
        repeat (20) @(negedge CORE_CLK);
        chk(CPU_CLK_EN, 0);
        kick(3, 0, 4096, 4112);
        rw(1'b1, 8'h00, 32'h0);
        u_core.enter(pwr_wake_pkg::MODE_DEEP_SLEEP, 2, '1);
        kick(2, 0, 4, 16);
        u_core.enter(pwr_wake_pkg::MODE_POWER_DOWN, 2, '1);
        chk({IRC_PWR_EN, FLASH_PWR_EN, FLASH_ACCESS_EN}, 0);
        kick(0, 1, 24, 40);
        chk({FLASH_ACCESS_EN, CPU_CLK_SRC}, 0);
        repeat (40) @(negedge CORE_CLK);
        chk(FLASH_ACCESS_EN, 1);
        u_core.enter(pwr_wake_pkg::MODE_DEEP_PD, 2, '1);
        chk({CPU_CLK_EN, DEEP_PD_ACTIVE}, 2'h2);
        @(posedge CORE_CLK);
        RTC_DPD_REQ <= 1'b1;
        u_core.enter(pwr_wake_pkg::MODE_DEEP_PD, 2, '1);
        chk(DEEP_PD_ACTIVE, 1);
        @(posedge CORE_CLK);
        {IRQ_LINES, RTC_DPD_REQ} <= {32'h2, 1'b0};
        repeat (20) @(negedge CORE_CLK);
        chk(DEEP_PD_ACTIVE, 1);
        kick(0, 1, 24, 40);
        chk(DEEP_PD_ACTIVE, 0);
        @(posedge CORE_CLK);
        CORE_SUPPLY_OK <= 1'b0;
        repeat (10) @(negedge CORE_CLK);
        chk(RTC_SUPPLY_BATTERY, 1);
        test_done();
    end
endmodule

// file: verif/pwr_wake_props.sv
// assertion checker bound to the power mode and wake-up controller
`timescale 1ns/1ps
module pwr_wake_props (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // watched ports
    input wire logic CORE_SUPPLY_OK,
    input wire logic USB_PLL_EN,
    input wire logic USB_PLL_PWR,
    input wire logic MAIN_PLL_EN,
    input wire logic [7:0] CPU_CLK_DIV,
    input wire logic [7:0] USB_CLK_DIV,
    input wire logic IRC_OUT_EN,
    input wire logic IRC_PWR_EN,
    input wire logic RTC_OSC_EN,
    input wire logic RTC_SUPPLY_BATTERY,
    input wire logic FLASH_PWR_EN,
    input wire logic FLASH_ACCESS_EN,
    input wire logic DEEP_PD_ACTIVE
);
    default clocking dc @(posedge CORE_CLK);
    endclocking
    default disable iff (!RSTN);
    AST_USB_PLL_OFF:
        assert property (disable iff (1'b0) !RSTN |-> !USB_PLL_EN && !USB_PLL_PWR)
        else $error("usb pll on in reset");
    AST_RTC_OSC_ON: assert property (RTC_OSC_EN)
        else $error("rtc oscillator stopped");
    AST_DS_CLEAR:
        assert property ($fell(IRC_OUT_EN) |-> ##[0:1]
            (!MAIN_PLL_EN && CPU_CLK_DIV == 8'h00 && USB_CLK_DIV == 8'h00))
        else $error("pll or dividers kept on entry");
    AST_PD_OFF: assert property (!IRC_PWR_EN |-> !FLASH_PWR_EN && !IRC_OUT_EN)
        else $error("flash or rc output on without rc power");
    AST_FLASH_GATE: assert property (FLASH_ACCESS_EN |-> FLASH_PWR_EN)
        else $error("flash access without flash power");
    AST_FLASH_WAIT: assert property ($rose(FLASH_PWR_EN) |-> !FLASH_ACCESS_EN [*8])
        else $error("flash access too early");
    AST_DPD_OFF: assert property (DEEP_PD_ACTIVE |-> !IRC_PWR_EN && !FLASH_PWR_EN)
        else $error("power left on in deep power-down");
    AST_SUPPLY_SWAP:
        assert property ($fell(CORE_SUPPLY_OK) |-> ##[1:8] RTC_SUPPLY_BATTERY)
        else $error("no switch to battery");
endmodule
bind power_mode_wakeup_ctrl pwr_wake_props u_props (.*);
